// [hdl/fsg_cfg.svh]
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define FSG_WORD_W 16
`define FSG_ADDR_W 16
`define FSG_APB_AW 8
`define FSG_LOCK_W 6

// ----------------------------------------------------------------
// Flash geometry defaults (in 16-bit words)
// ----------------------------------------------------------------
`define FSG_FLASH_WORDS 32'h0000_4000
`define FSG_BOOT_WORDS 32'h0000_0800

// ----------------------------------------------------------------
// Lock field positions and values (one = unprogrammed)
// ----------------------------------------------------------------
`define FSG_LK_APP_LSB 0
`define FSG_LK_TBL_LSB 2
`define FSG_LK_BOOT_LSB 4
`define FSG_LK_NONE 2'h3
`define FSG_LOCK_RST 6'h3f

// ----------------------------------------------------------------
// Production signature row layout read at reset
// ----------------------------------------------------------------
`define FSG_SIG_BASE 16'h0000
`define FSG_CAL_AUTO 4
`define FSG_IDX_DEVID 4
`define FSG_IDX_SER_LO 5
`define FSG_IDX_SER_HI 6
`define FSG_IDX_LOCK 7
`define FSG_LD_WORDS 8
`define FSG_LD_IDX_W 3

// ----------------------------------------------------------------
// APB register offsets and status bits
// ----------------------------------------------------------------
`define FSG_REG_STATUS 8'h00
`define FSG_REG_LOCK 8'h04
`define FSG_REG_DEVID 8'h08
`define FSG_REG_SERIAL 8'h0c
`define FSG_REG_DENY 8'h10
`define FSG_ST_BUSY 0
`define FSG_ST_LOADED 1
`define FSG_ST_LASTDENY 2
`define FSG_DENY_W 16

`endif

// [hdl/fsg_pkg.sv]
`include "fsg_cfg.svh"

package fsg_pkg;
    typedef enum logic [0:0] {FSG_SRC_CPU, FSG_SRC_PROG} fsg_src_t;
    typedef enum logic [2:0] {
        FSG_SP_FLASH, FSG_SP_PROD, FSG_SP_USER, FSG_SP_FUSE, FSG_SP_LOCK
    } fsg_space_t;
    typedef enum logic [2:0] {
        FSG_OP_READ, FSG_OP_WRITE, FSG_OP_ERASE_PAGE, FSG_OP_CHIP_ERASE, FSG_OP_ERASE_USER
    } fsg_op_t;
    typedef enum logic [1:0] {FSG_SEC_APP, FSG_SEC_TBL, FSG_SEC_BOOT} fsg_sect_t;

    typedef struct packed {
        fsg_src_t src;
        fsg_op_t op;
        fsg_space_t space;
        logic [`FSG_ADDR_W-1:0] addr;
        logic [`FSG_WORD_W-1:0] wdata;
        logic [`FSG_ADDR_W-1:0] fetch_addr;
    } fsg_req_t;

    typedef struct packed {
        logic valid;
        fsg_op_t op;
        fsg_space_t space;
        logic [`FSG_ADDR_W-1:0] addr;
        logic [`FSG_WORD_W-1:0] wdata;
    } fsg_arr_req_t;

    typedef struct packed {
        logic done;
        logic denied;
        logic [`FSG_WORD_W-1:0] rdata;
    } fsg_resp_t;
endpackage

// [hdl/fsg_cal_loader.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"

module fsg_cal_loader (
    input wire logic pclk,
    input wire logic presetn,
    output fsg_pkg::fsg_arr_req_t arr_req,
    input wire logic arr_done,
    input wire logic [`FSG_WORD_W-1:0] arr_rdata,
    output logic word_valid,
    output logic [`FSG_LD_IDX_W-1:0] word_idx,
    output logic [`FSG_WORD_W-1:0] word_data,
    output logic done
);
    import fsg_pkg::*;

    typedef enum logic [1:0] {LD_READ, LD_DONE} fsg_ld_state_t;

    fsg_ld_state_t st_q, st_d;
    logic [`FSG_LD_IDX_W-1:0] idx_q, idx_d;
    logic vld_q, vld_d;
    logic [`FSG_LD_IDX_W-1:0] widx_q, widx_d;
    logic [`FSG_WORD_W-1:0] wdat_q, wdat_d;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        vld_d = 1'b0;
        widx_d = widx_q;
        wdat_d = wdat_q;
        case (st_q)
            LD_READ: begin
                if (arr_done) begin
                    vld_d = 1'b1;
                    widx_d = idx_q;
                    wdat_d = arr_rdata;
                    idx_d = idx_q + 1'b1;
                    if (idx_q == `FSG_LD_IDX_W'(`FSG_LD_WORDS - 1)) begin
                        st_d = LD_DONE;
                    end
                end
            end
            default: begin
                st_d = LD_DONE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= LD_READ;
            idx_q <= '0;
            vld_q <= 1'b0;
            widx_q <= '0;
            wdat_q <= '0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            vld_q <= vld_d;
            widx_q <= widx_d;
            wdat_q <= wdat_d;
        end
    end

    // Last word fetched is the stored lock setting, not a signature word
    always_comb begin
        arr_req = '0;
        arr_req.valid = (st_q == LD_READ);
        arr_req.op = FSG_OP_READ;
        if (idx_q == `FSG_LD_IDX_W'(`FSG_IDX_LOCK)) begin
            arr_req.space = FSG_SP_LOCK;
            arr_req.addr = '0;
        end else begin
            arr_req.space = FSG_SP_PROD;
            arr_req.addr = `FSG_SIG_BASE + `FSG_ADDR_W'(idx_q);
        end
    end

    assign word_valid = vld_q;
    assign word_idx = widx_q;
    assign word_data = wdat_q;
    // Held off one cycle so the loaded lock word is in place before requests
    assign done = (st_q == LD_DONE) && !vld_q;
endmodule

`default_nettype wire

// [hdl/flash_section_access_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"

module flash_section_access_guard #(
    parameter int unsigned FLASH_WORDS = `FSG_FLASH_WORDS,
    parameter int unsigned BOOT_WORDS = `FSG_BOOT_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FSG_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire fsg_pkg::fsg_req_t req,
    output logic req_ready,
    output fsg_pkg::fsg_resp_t resp,
    output fsg_pkg::fsg_arr_req_t arr_req,
    input wire logic arr_done,
    input wire logic [`FSG_WORD_W-1:0] arr_rdata,
    output logic cal_valid,
    output logic [`FSG_LD_IDX_W-1:0] cal_idx,
    output logic [`FSG_WORD_W-1:0] cal_data
);
    import fsg_pkg::*;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    // table sized like boot
    localparam logic [`FSG_ADDR_W-1:0] BOOT_START = `FSG_ADDR_W'(FLASH_WORDS - BOOT_WORDS);
    localparam logic [`FSG_ADDR_W-1:0] TBL_START = `FSG_ADDR_W'(FLASH_WORDS - 2 * BOOT_WORDS);

    if (`FSG_WORD_W != 16 || FLASH_WORDS > 32'h0001_0000 || BOOT_WORDS == 0 ||
        2 * BOOT_WORDS > FLASH_WORDS) begin : g_bad_geometry
        $error("flash_section_access_guard: unsupported flash geometry");
    end

    typedef enum logic [1:0] {S_IDLE, S_ARRAY, S_CE_FLASH, S_CE_LOCKS} fsg_state_t;

    function automatic fsg_sect_t sect_of(input logic [`FSG_ADDR_W-1:0] a);
        if (a >= BOOT_START) begin
            return FSG_SEC_BOOT;
        end else if (a >= TBL_START) begin
            return FSG_SEC_TBL;
        end
        return FSG_SEC_APP;
    endfunction

    function automatic logic [1:0] lock_of(input logic [`FSG_LOCK_W-1:0] lk,
                                           input fsg_sect_t s);
        case (s)
            FSG_SEC_BOOT: return lk[`FSG_LK_BOOT_LSB +: 2];
            FSG_SEC_TBL: return lk[`FSG_LK_TBL_LSB +: 2];
            default: return lk[`FSG_LK_APP_LSB +: 2];
        endcase
    endfunction

    function automatic logic permit(input fsg_req_t r, input logic [`FSG_LOCK_W-1:0] lk);
        logic [1:0] f;
        logic is_mod;
        logic rd_blk;
        logic wr_blk;
        f = lock_of(lk, sect_of(r.addr));
        is_mod = (r.op != FSG_OP_READ);
        rd_blk = !f[1];
        wr_blk = (f != `FSG_LK_NONE);
        if (r.op == FSG_OP_ERASE_USER) begin
            return r.space == FSG_SP_USER;
        end
        case (r.space)
            FSG_SP_FLASH: begin
                if (r.op == FSG_OP_CHIP_ERASE) begin
                    return r.src == FSG_SRC_PROG;
                end
                if (is_mod) begin
                    return !wr_blk &&
                           (r.src == FSG_SRC_PROG || sect_of(r.fetch_addr) == FSG_SEC_BOOT);
                end
                return !rd_blk ||
                       (r.src == FSG_SRC_CPU && sect_of(r.fetch_addr) == sect_of(r.addr));
            end
            FSG_SP_PROD: return !is_mod;
            FSG_SP_USER: return r.op != FSG_OP_CHIP_ERASE;
            FSG_SP_FUSE: return !is_mod || (r.src == FSG_SRC_PROG && r.op == FSG_OP_WRITE);
            FSG_SP_LOCK: return r.op == FSG_OP_READ || r.op == FSG_OP_WRITE;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic stricter(input logic [`FSG_LOCK_W-1:0] old_lk,
                                      input logic [`FSG_LOCK_W-1:0] new_lk);
        return (new_lk & ~old_lk) == '0;
    endfunction

    // ----------------------------------------------------------------
    // Reset-time loader
    // ----------------------------------------------------------------
    fsg_arr_req_t ld_arr;
    logic ld_vld;
    logic [`FSG_LD_IDX_W-1:0] ld_idx;
    logic [`FSG_WORD_W-1:0] ld_data;
    logic ld_done;

    fsg_cal_loader u_loader (
        .pclk(pclk),
        .presetn(presetn),
        .arr_req(ld_arr),
        .arr_done(arr_done),
        .arr_rdata(arr_rdata),
        .word_valid(ld_vld),
        .word_idx(ld_idx),
        .word_data(ld_data),
        .done(ld_done)
    );

    // ----------------------------------------------------------------
    // Access state machine
    // ----------------------------------------------------------------
    fsg_state_t st_q, st_d;
    logic [`FSG_LOCK_W-1:0] lock_q, lock_d;
    fsg_arr_req_t arr_q, arr_d;
    fsg_resp_t resp_q, resp_d;
    logic [`FSG_DENY_W-1:0] deny_q, deny_d;
    logic lastdeny_q, lastdeny_d;
    logic accept;
    logic ok;
    logic fsm_lock_we;
    logic apb_fire;
    logic apb_lock_wr;
    logic [`FSG_LOCK_W-1:0] apb_lock_val;

    assign req_ready = (st_q == S_IDLE) && ld_done;
    assign accept = req_valid && req_ready;
    assign ok = permit(req, lock_q);
    assign apb_lock_val = pwdata[`FSG_LOCK_W-1:0];
    assign apb_lock_wr = psel && penable && pwrite && (paddr == `FSG_REG_LOCK);
    // Port lock updates own the lock this cycle; software waits a cycle
    assign fsm_lock_we = (accept && ok && req.space == FSG_SP_LOCK && req.op == FSG_OP_WRITE) ||
                         (st_q == S_CE_LOCKS);
    assign pready = !(apb_lock_wr && fsm_lock_we);
    assign apb_fire = psel && penable && pready;

    always_comb begin
        st_d = st_q;
        lock_d = lock_q;
        arr_d = arr_q;
        resp_d = '0;
        deny_d = deny_q;
        lastdeny_d = lastdeny_q;
        if (ld_vld && ld_idx == `FSG_LD_IDX_W'(`FSG_IDX_LOCK)) begin
            lock_d = ld_data[`FSG_LOCK_W-1:0];
        end
        case (st_q)
            S_IDLE: begin
                if (accept) begin
                    lastdeny_d = 1'b0;
                    if (!ok) begin
                        resp_d.done = 1'b1;
                        resp_d.denied = 1'b1;
                        deny_d = deny_q + 1'b1;
                        lastdeny_d = 1'b1;
                    end else if (req.space == FSG_SP_LOCK) begin
                        resp_d.done = 1'b1;
                        resp_d.rdata = `FSG_WORD_W'(lock_q);
                        if (req.op == FSG_OP_WRITE) begin
                            if (stricter(lock_q, req.wdata[`FSG_LOCK_W-1:0])) begin
                                lock_d = req.wdata[`FSG_LOCK_W-1:0];
                            end else begin
                                resp_d.denied = 1'b1;
                                deny_d = deny_q + 1'b1;
                                lastdeny_d = 1'b1;
                            end
                        end
                    end else begin
                        arr_d.valid = 1'b1;
                        arr_d.op = req.op;
                        arr_d.space = req.space;
                        arr_d.addr = req.addr;
                        arr_d.wdata = req.wdata;
                        st_d = (req.op == FSG_OP_CHIP_ERASE) ? S_CE_FLASH : S_ARRAY;
                    end
                end
                // After the port clear, so a software refusal still sets the flag
                if (ld_done && apb_fire && pwrite && paddr == `FSG_REG_LOCK) begin
                    if (stricter(lock_q, apb_lock_val)) begin
                        lock_d = apb_lock_val;
                    end else begin
                        deny_d = deny_d + 1'b1;
                        lastdeny_d = 1'b1;
                    end
                end
            end
            S_ARRAY: begin
                if (arr_done) begin
                    arr_d = '0;
                    resp_d.done = 1'b1;
                    resp_d.rdata = arr_rdata;
                    st_d = S_IDLE;
                end
            end
            S_CE_FLASH: begin
                if (arr_done) begin
                    arr_d = '0;
                    st_d = S_CE_LOCKS;
                end
            end
            S_CE_LOCKS: begin
                lock_d = `FSG_LOCK_RST;
                resp_d.done = 1'b1;
                st_d = S_IDLE;
            end
            default: begin
                st_d = S_IDLE;
                arr_d = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            lock_q <= '0;
            arr_q <= '0;
            resp_q <= '0;
            deny_q <= '0;
            lastdeny_q <= 1'b0;
        end else begin
            st_q <= st_d;
            lock_q <= lock_d;
            arr_q <= arr_d;
            resp_q <= resp_d;
            deny_q <= deny_d;
            lastdeny_q <= lastdeny_d;
        end
    end

    // Loader owns the array until it finishes
    assign arr_req = ld_done ? arr_q : ld_arr;
    assign resp = resp_q;

    // ----------------------------------------------------------------
    // Signature capture
    // ----------------------------------------------------------------
    logic cal_vld_q, cal_vld_d;
    logic [`FSG_LD_IDX_W-1:0] cal_idx_q, cal_idx_d;
    logic [`FSG_WORD_W-1:0] cal_dat_q, cal_dat_d;
    logic [`FSG_WORD_W-1:0] devid_q, devid_d;
    logic [31:0] serial_q, serial_d;

    always_comb begin
        cal_vld_d = 1'b0;
        cal_idx_d = cal_idx_q;
        cal_dat_d = cal_dat_q;
        devid_d = devid_q;
        serial_d = serial_q;
        if (ld_vld) begin
            if (ld_idx < `FSG_LD_IDX_W'(`FSG_CAL_AUTO)) begin
                cal_vld_d = 1'b1;
                cal_idx_d = ld_idx;
                cal_dat_d = ld_data;
            end
            if (ld_idx == `FSG_LD_IDX_W'(`FSG_IDX_DEVID)) begin
                devid_d = ld_data;
            end
            if (ld_idx == `FSG_LD_IDX_W'(`FSG_IDX_SER_LO)) begin
                serial_d[15:0] = ld_data;
            end
            if (ld_idx == `FSG_LD_IDX_W'(`FSG_IDX_SER_HI)) begin
                serial_d[31:16] = ld_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_vld_q <= 1'b0;
            cal_idx_q <= '0;
            cal_dat_q <= '0;
            devid_q <= '0;
            serial_q <= '0;
        end else begin
            cal_vld_q <= cal_vld_d;
            cal_idx_q <= cal_idx_d;
            cal_dat_q <= cal_dat_d;
            devid_q <= devid_d;
            serial_q <= serial_d;
        end
    end

    assign cal_valid = cal_vld_q;
    assign cal_idx = cal_idx_q;
    assign cal_data = cal_dat_q;

    // ----------------------------------------------------------------
    // APB read side
    // ----------------------------------------------------------------
    logic [31:0] prdata_q, prdata_d;
    logic mapped;

    assign mapped = (paddr == `FSG_REG_STATUS) || (paddr == `FSG_REG_LOCK) ||
                    (paddr == `FSG_REG_DEVID) || (paddr == `FSG_REG_SERIAL) ||
                    (paddr == `FSG_REG_DENY);
    assign pslverr = psel && penable && pready && !mapped;

    always_comb begin
        prdata_d = prdata_q;
        if (psel && !penable) begin
            prdata_d = '0;
            case (paddr)
                `FSG_REG_STATUS: begin
                    prdata_d[`FSG_ST_BUSY] = (st_q != S_IDLE);
                    prdata_d[`FSG_ST_LOADED] = ld_done;
                    prdata_d[`FSG_ST_LASTDENY] = lastdeny_q;
                end
                `FSG_REG_LOCK: prdata_d[`FSG_LOCK_W-1:0] = lock_q;
                `FSG_REG_DEVID: prdata_d[`FSG_WORD_W-1:0] = devid_q;
                `FSG_REG_SERIAL: prdata_d = serial_q;
                `FSG_REG_DENY: prdata_d[`FSG_DENY_W-1:0] = deny_q;
                default: prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    prod_row_ro_a: assert property (
        accept && req.space == FSG_SP_PROD && req.op != FSG_OP_READ |=> resp.done && resp.denied)
        else $error("write to production row not refused");
    fuse_cpu_block_a: assert property (
        accept && req.space == FSG_SP_FUSE && req.src == FSG_SRC_CPU && req.op == FSG_OP_WRITE
        |=> resp.denied && !arr_req.valid)
        else $error("cpu fuse write not refused");
    store_boot_only_a: assert property (
        accept && req.src == FSG_SRC_CPU && req.space == FSG_SP_FLASH &&
        req.op == FSG_OP_WRITE && req.fetch_addr < BOOT_START |=> resp.denied)
        else $error("store outside boot not refused");
    lock_tighten_a: assert property (
        ld_done && $past(ld_done) && $past(st_q) != S_CE_LOCKS |-> (lock_q & ~$past(lock_q)) == '0)
        else $error("lock loosened outside chip erase");
    ce_lock_order_a: assert property (
        st_q == S_CE_FLASH && arr_done |=> st_q == S_CE_LOCKS && lock_q == $past(lock_q)
        ##1 lock_q == `FSG_LOCK_RST && resp.done)
        else $error("locks not cleared after flash erase");
    ce_user_kept_a: assert property (
        arr_req.valid && arr_req.op == FSG_OP_CHIP_ERASE |-> arr_req.space == FSG_SP_FLASH)
        else $error("chip erase reached a non-flash space");
    deny_no_effect_a: assert property (
        accept && !ok && !apb_lock_wr |=> !arr_req.valid && lock_q == $past(lock_q) &&
        st_q == S_IDLE)
        else $error("refused access had side effects");
    user_row_open_a: assert property (
        accept && req.space == FSG_SP_USER && req.op inside {FSG_OP_READ, FSG_OP_WRITE}
        |=> arr_req.valid && arr_req.space == FSG_SP_USER)
        else $error("user row access not forwarded");
    cal_push_a: assert property (
        ld_vld && ld_idx < `FSG_LD_IDX_W'(`FSG_CAL_AUTO) |=> cal_valid && cal_data == $past(ld_data))
        else $error("calibration word not pushed");

    ce_done_c: cover property (st_q == S_CE_FLASH ##[1:50] st_q == S_CE_LOCKS);
    deny_c: cover property (accept && !ok);
    lock_tight_c: cover property (fsm_lock_we && st_q == S_IDLE ##1 resp.done && !resp.denied);
endmodule

`default_nettype wire

// [dv/fsg_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"
module fsg_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire fsg_pkg::fsg_arr_req_t arr_req,
    output logic arr_done,
    output logic [`FSG_WORD_W-1:0] arr_rdata
);
    import fsg_pkg::*;
    // ---------
    // Array
    // ---------
    // Slow on purpose; read data toggles outside its pulse
    logic [1:0] wait_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 2'h0;
            arr_done <= 1'h0;
            arr_rdata <= 16'h0;
        end else begin
            arr_done <= 1'h0;
            arr_rdata <= ~arr_rdata;
            if (arr_req.valid && !arr_done) begin
                wait_q <= wait_q + 2'h1;
            end
            if (arr_req.valid && !arr_done && wait_q == 2'h2) begin
                wait_q <= 2'h0;
                arr_done <= 1'h1;
                // word data, factory row, locks unprogrammed
                arr_rdata <= (arr_req.space == FSG_SP_PROD) ? 16'h1000 + arr_req.addr :
                    (arr_req.space == FSG_SP_LOCK) ? 16'h003f : 16'h5a00 ^ arr_req.addr;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"
module tb_top;
    import fsg_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, got;
    logic pready, pslverr, err, req_valid = 1'h0, req_ready, arr_done, cal_valid;
    fsg_req_t req = '0;
    fsg_resp_t resp;
    fsg_arr_req_t arr_req;
    logic [15:0] arr_rdata, cal_data;
    logic [2:0] cal_idx;
    int n_mismatch = 0, tests_run = 0, n_cal = 0;
    always #5 pclk = ~pclk;
    flash_section_access_guard i_flash_section_access_guard (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .resp(resp), .arr_req(arr_req),
        .arr_done(arr_done), .arr_rdata(arr_rdata), .cal_valid(cal_valid),
        .cal_idx(cal_idx), .cal_data(cal_data));
    fsg_flash_model i_fsg_flash_model (.pclk(pclk), .presetn(presetn), .arr_req(arr_req),
        .arr_done(arr_done), .arr_rdata(arr_rdata));
    // ---------
    // Helpers
    // ---------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        if (i == 20) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic port(input fsg_src_t s, input fsg_op_t o, input fsg_space_t sp,
                        input logic [15:0] a, input logic [15:0] f, input logic dn);
        int i;
        logic touched;
        touched = 1'h0;
        req <= '{s, o, sp, a, 16'h1234, f};
        req_valid <= 1'h1;
        for (i = 0; i < 100; i++) begin
            @(posedge pclk);
            if (req_ready === 1'h1) break;
        end
        if (i == 100) begin
            n_mismatch++;
            complete_run();
        end
        req_valid <= 1'h0;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            touched |= (arr_req.valid === 1'h1);
            if (resp.done === 1'h1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            complete_run();
        end
        got = {16'h0, resp.rdata};
        chk("denied", {31'h0, dn}, {31'h0, resp.denied});
        chk("array touched", {31'h0, !dn}, {31'h0, touched});
    endtask
    always @(posedge pclk) begin
        if (cal_valid === 1'h1) begin
            chk("cal word", 32'h1000 + 32'(cal_idx), {16'h0, cal_data});
            n_cal++;
        end
    end
    // ---------
    // Sequence
    // ---------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        port(FSG_SRC_PROG, FSG_OP_READ, FSG_SP_PROD, 16'h4, 16'h0, 1'h0);
        chk("prod read", 32'h1004, got);
        chk("cal count", 32'h4, 32'(n_cal));
        port(FSG_SRC_CPU, FSG_OP_READ, FSG_SP_PROD, 16'h5, 16'h0, 1'h0);
        port(FSG_SRC_PROG, FSG_OP_WRITE, FSG_SP_PROD, 16'h0, 16'h0, 1'h1);
        port(FSG_SRC_CPU, FSG_OP_ERASE_PAGE, FSG_SP_PROD, 16'h0, 16'h3900, 1'h1);
        port(FSG_SRC_CPU, FSG_OP_WRITE, FSG_SP_FLASH, 16'h10, 16'h0100, 1'h1);
        port(FSG_SRC_CPU, FSG_OP_WRITE, FSG_SP_FLASH, 16'h10, 16'h3900, 1'h0);
        port(FSG_SRC_CPU, FSG_OP_WRITE, FSG_SP_FLASH, 16'h3810, 16'h3900, 1'h0);
        port(FSG_SRC_CPU, FSG_OP_WRITE, FSG_SP_USER, 16'h2, 16'h0100, 1'h0);
        port(FSG_SRC_PROG, FSG_OP_ERASE_USER, FSG_SP_USER, 16'h0, 16'h0, 1'h0);
        port(FSG_SRC_CPU, FSG_OP_WRITE, FSG_SP_FUSE, 16'h1, 16'h3900, 1'h1);
        port(FSG_SRC_PROG, FSG_OP_WRITE, FSG_SP_FUSE, 16'h1, 16'h0, 1'h0);
        port(FSG_SRC_CPU, FSG_OP_CHIP_ERASE, FSG_SP_FLASH, 16'h0, 16'h3900, 1'h1);
        $display("access table done");
        apb(1'h0, `FSG_REG_DEVID, 32'h0);
        chk("devid", 32'h1004, rd);
        apb(1'h0, `FSG_REG_SERIAL, 32'h0);
        chk("serial", 32'h1006_1005, rd);
        apb(1'h0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'h0, `FSG_REG_LOCK, 32'h0);
        chk("lock reset", 32'h3f, rd);
        apb(1'h1, `FSG_REG_LOCK, 32'h3e);
        port(FSG_SRC_PROG, FSG_OP_WRITE, FSG_SP_FLASH, 16'h10, 16'h0, 1'h1);
        port(FSG_SRC_PROG, FSG_OP_READ, FSG_SP_FLASH, 16'h10, 16'h0, 1'h0);
        chk("flash read", 32'h5a10, got);
        apb(1'h1, `FSG_REG_LOCK, 32'h32);
        port(FSG_SRC_PROG, FSG_OP_READ, FSG_SP_FLASH, 16'h3000, 16'h0, 1'h1);
        apb(1'h1, `FSG_REG_LOCK, 32'h22);
        port(FSG_SRC_PROG, FSG_OP_WRITE, FSG_SP_FLASH, 16'h3810, 16'h0, 1'h1);
        apb(1'h1, `FSG_REG_LOCK, 32'h3f);
        port(FSG_SRC_PROG, FSG_OP_WRITE, FSG_SP_LOCK, 16'h0, 16'h0, 1'h1);
        chk("lock via port", 32'h22, got);
        apb(1'h0, `FSG_REG_LOCK, 32'h0);
        chk("lock kept", 32'h22, rd);
        apb(1'h0, `FSG_REG_STATUS, 32'h0);
        chk("status", 32'h6, rd);
        apb(1'h0, `FSG_REG_DENY, 32'h0);
        chk("deny count", 32'ha, rd);
        port(FSG_SRC_PROG, FSG_OP_CHIP_ERASE, FSG_SP_FLASH, 16'h0, 16'h0, 1'h0);
        apb(1'h0, `FSG_REG_LOCK, 32'h0);
        chk("lock erased", 32'h3f, rd);
        $display("lock sequence done");
        complete_run();
    end
endmodule
`default_nettype wire
